/* File: wbca_pkg.sv */
// package: constants and types for the word bus cycle adapter
package wbca_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STATUS_HOLD_CLKS = 2;
  localparam int unsigned DONE_HOLD_CLKS = 2;
  localparam int unsigned HOLD_TIME_NS = 25;
  localparam logic [1:0] WAIT_CNT_W0 = 2'h0;
  localparam logic [1:0] WAIT_CNT_W1 = 2'h1;
  localparam logic [1:0] WAIT_CNT_W2 = 2'h2;
  localparam logic [1:0] WAIT_CNT_MAX = 2'h3;
  localparam logic [1:0] DEFAULT_WAITS = 2'h2;
  localparam int unsigned LANE0 = 0;
  localparam int unsigned LANE1 = 1;
  localparam int unsigned LANE2 = 2;
  localparam int unsigned LANE3 = 3;
  typedef enum logic [2:0] {
    WBCA_IDLE = 3'h1,
    WBCA_WAIT = 3'h2,
    WBCA_DONE = 3'h4
  } wbca_state_type;
endpackage : wbca_pkg

/* File: wbca_lane_if.sv */
// interface: byte lane translation signals between top and lane decoder
`timescale 1ns/1ns
`default_nettype none
interface wbca_lane_if;
  logic [3:0] byte_lane_enables_n;
  logic word_select;
  logic upper_byte_strobe_n;
  logic lower_byte_strobe_n;
  modport dec (input byte_lane_enables_n, output word_select, output upper_byte_strobe_n,
               output lower_byte_strobe_n);
  modport top (output byte_lane_enables_n, input word_select, input upper_byte_strobe_n,
               input lower_byte_strobe_n);
endinterface : wbca_lane_if
`default_nettype wire

/* File: wbca_lane_dec.sv */
// module: byte lane enables to word select and byte strobes
`timescale 1ns/1ns
`default_nettype none
module wbca_lane_dec
  import wbca_pkg::*;
(
  wbca_lane_if.dec lanes
);
  logic [3:0] act;
  assign act = ~lanes.byte_lane_enables_n;
  // low pair busy selects the even word; else the odd word
  assign lanes.word_select = ~(act[LANE0] | act[LANE1]);
  assign lanes.lower_byte_strobe_n =
    ~(act[LANE0] | (act[LANE2] & ~act[LANE0] & ~act[LANE1]));
  assign lanes.upper_byte_strobe_n =
    ~(act[LANE1] | (act[LANE3] & ~act[LANE0] & ~act[LANE1]));
endmodule : wbca_lane_dec
`default_nettype wire

/* File: wbca_adapter.sv */
// module: top of the word bus cycle adapter
//
// Function
// - lower strobe for lane 0 or lone 2
// - upper strobe for lane 1 or lone 3
// - word select low for lanes 0/1
// - illegal lane patterns give any outputs
// - status from cycle type and wait ticks
// - wait ticks mark first and second waits
// - status valid two full clocks
// - sequencer done only after required wait count; acknowledge follows request
// - half-rate clock divides clock by two
// - done acknowledge lasts two clocks
// - pulse flag loads request and half clock
// - done when request and half clock, or flag
// - one select for controller and arbiter
`timescale 1ns/1ns
`default_nettype none
module wbca_adapter
  import wbca_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // processor cycle start and type
  input wire logic cycle_start,
  input wire logic legacy_cycle,
  input wire logic data_code,
  input wire logic mem_io,
  input wire logic write_read,
  input wire logic [3:0] byte_lane_enables_n,
  input wire logic [1:0] wait_count,
  // external done request
  input wire logic async_done_request,
  // translated bus
  output logic word_select,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic cycle_status_low_n,
  output logic cycle_status_high_n,
  output logic first_wait_tick,
  output logic second_wait_tick,
  output logic half_rate_clk,
  output logic legacy_select,
  output logic system_bus_mode_strap,
  output logic done_ack_n
);
  ////////////////////////////////////////////////////////////////////////////////
  wbca_lane_if lanes ();
  wbca_state_type state_r;
  logic [1:0] wait_cnt_r;
  logic [1:0] wait_need_r;
  logic done_pulse_flag_r;
  logic half_clk_r;
  logic done_now;
  logic wait_over;

  // one wait state of the current cycle, picked by its count
  function automatic logic wait_at(input wbca_state_type s, input logic [1:0] c, input logic [1:0] w);
    wait_at = (s == WBCA_WAIT) && (c == w);
  endfunction : wait_at

  // status stands over both ticks, which is what gives it two full clocks
  function automatic logic status_window(input wbca_state_type s, input logic [1:0] c);
    status_window = wait_at(s, c, WAIT_CNT_W1) || wait_at(s, c, WAIT_CNT_W2);
  endfunction : status_window

  assign lanes.byte_lane_enables_n = byte_lane_enables_n;
  wbca_lane_dec u_dec (.lanes(lanes));

  assign done_now = async_done_request & half_clk_r;
  assign wait_over = (state_r == WBCA_WAIT) && (wait_cnt_r >= wait_need_r);

  ////////////////////////////////////////////////////////////////////////////////
  // half-rate clock divider
  // frozen with clk_en, so it stays a phase of the enabled clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_clk_r <= 1'b0;
    end else if (clk_en) begin
      half_clk_r <= ~half_clk_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle sequencer and wait counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= WBCA_IDLE;
      wait_cnt_r <= WAIT_CNT_W0;
      wait_need_r <= DEFAULT_WAITS;
    end else if (clk_en) begin
      unique case (state_r)
        WBCA_IDLE: begin
          if (cycle_start) begin
            state_r <= WBCA_WAIT;
            wait_cnt_r <= WAIT_CNT_W1;
            // two waits minimum so status holds two clocks
            wait_need_r <= (wait_count < WAIT_CNT_W2) ? WAIT_CNT_W2 : wait_count;
          end
        end
        WBCA_WAIT: begin
          if (wait_over) begin
            state_r <= WBCA_DONE;
          end else if (wait_cnt_r != WAIT_CNT_MAX) begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
          end
        end
        WBCA_DONE: begin
          state_r <= WBCA_IDLE;
          wait_cnt_r <= WAIT_CNT_W0;
        end
        default: begin
          state_r <= WBCA_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs: lanes, wait ticks, status, select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_select <= 1'b0;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      first_wait_tick <= 1'b0;
      second_wait_tick <= 1'b0;
      cycle_status_low_n <= 1'b1;
      cycle_status_high_n <= 1'b1;
      legacy_select <= 1'b0;
      half_rate_clk <= 1'b0;
      system_bus_mode_strap <= 1'b0;
    end else if (clk_en) begin
      word_select <= lanes.word_select;
      upper_byte_strobe_n <= lanes.upper_byte_strobe_n;
      lower_byte_strobe_n <= lanes.lower_byte_strobe_n;
      first_wait_tick <= wait_at(state_r, wait_cnt_r, WAIT_CNT_W1);
      second_wait_tick <= wait_at(state_r, wait_cnt_r, WAIT_CNT_W2);
      // low_n for memory write or code fetch; high_n for reads or i/o
      cycle_status_low_n <= ~(status_window(state_r, wait_cnt_r) &
        (write_read | ~data_code) & mem_io);
      cycle_status_high_n <= ~(status_window(state_r, wait_cnt_r) &
        (~write_read | ~mem_io));
      legacy_select <= legacy_cycle;
      half_rate_clk <= ~half_clk_r;
      system_bus_mode_strap <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // done acknowledge, stretched to two clocks by the pulse flag
  // limitation: follows the request and half clock, not the sequencer; the far side must not ask before its waits are over
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_pulse_flag_r <= 1'b0;
      done_ack_n <= 1'b1;
    end else if (clk_en) begin
      done_pulse_flag_r <= done_now;
      done_ack_n <= ~(done_now | done_pulse_flag_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_DONE_STRETCH: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && done_now |=> (!done_ack_n) [*2])
    else $error("done ack not held after pulse");
  AST_DONE_CAUSE: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !done_now && !done_pulse_flag_r |=> done_ack_n)
    else $error("done ack without cause");
  AST_FLAG_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> done_pulse_flag_r == $past(done_now))
    else $error("pulse flag not loaded");
  AST_HALF_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> half_clk_r != $past(half_clk_r))
    else $error("half clock did not toggle");
  AST_TICK_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && first_wait_tick ##1 clk_en |-> second_wait_tick)
    else $error("second tick not after first");
  AST_STATUS_TWO: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(cycle_status_high_n) && clk_en |=> !cycle_status_high_n)
    else $error("status shorter than two clocks");
  AST_LANE_EVEN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && (byte_lane_enables_n[LANE0] == 1'b0) |=> !word_select && !lower_byte_strobe_n)
    else $error("lane 0 not on even word low byte");
  AST_LANE_ODD: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && (byte_lane_enables_n == 4'h7) |=> word_select && !upper_byte_strobe_n)
    else $error("lone lane 3 mistranslated");
  AST_DONE_AFTER_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == WBCA_DONE |-> $past(wait_cnt_r) >= WAIT_CNT_W2)
    else $error("cycle ended before waits");
  AST_STATUS_LOW_TWO: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(cycle_status_low_n) && clk_en |=> !cycle_status_low_n)
    else $error("low status shorter than two clocks");
  AST_STATUS_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && state_r == WBCA_IDLE |=> cycle_status_low_n && cycle_status_high_n)
    else $error("status active outside a cycle");
  AST_TICK_ONE: assert property (@(posedge clk) disable iff (!reset_n)
    !(first_wait_tick && second_wait_tick))
    else $error("both wait ticks at once");
  AST_WAIT_NO_SKIP: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && state_r == WBCA_WAIT |=> state_r != WBCA_IDLE)
    else $error("cycle left wait without done");
  AST_SELECT_FOLLOW: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> legacy_select == $past(legacy_cycle))
    else $error("legacy select does not follow decoder");
  AST_LANE_PAIR_HI: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && (byte_lane_enables_n == 4'h3) |=> word_select && !upper_byte_strobe_n && !lower_byte_strobe_n)
    else $error("upper lane pair mistranslated");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(half_clk_r) && $stable(state_r) && $stable(done_ack_n))
    else $error("state moved while clock enable low");

  // cover points
  COV_CYCLE: cover property (@(posedge clk) state_r == WBCA_DONE);
  COV_DONE: cover property (@(posedge clk) !done_ack_n ##1 !done_ack_n);
  COV_ODD: cover property (@(posedge clk) word_select && !lower_byte_strobe_n);
  COV_WAIT3: cover property (@(posedge clk) state_r == WBCA_WAIT && wait_cnt_r == WAIT_CNT_MAX);
  COV_LOW_TWO: cover property (@(posedge clk) !cycle_status_low_n ##1 !cycle_status_low_n);
endmodule : wbca_adapter
`default_nettype wire

/* File: wbca_bus_partner.sv */
// model: legacy bus controller side answering translated cycles
`timescale 1ns/1ns
`default_nettype none
module wbca_bus_partner
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // translated bus
  input wire logic cycle_status_low_n,
  input wire logic cycle_status_high_n,
  input wire logic legacy_select,
  input wire logic system_bus_mode_strap,
  input wire logic done_ack_n,
  // answer speed
  input wire logic [3:0] answer_delay,
  output logic async_done_request
);
  logic [3:0] wait_r;
  logic arbiter_address_enable_n;
  // the arbiter owns the bus one clock after the select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arbiter_address_enable_n <= 1'b1;
    end else begin
      arbiter_address_enable_n <= ~legacy_select;
    end
  end
  // request held until the acknowledge is seen, so its stretch is visible
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 4'h0;
      async_done_request <= 1'b0;
    end else if (!done_ack_n) begin
      wait_r <= 4'h0;
      async_done_request <= 1'b0;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
      async_done_request <= (wait_r == 4'h1);
    end else if (!(cycle_status_low_n && cycle_status_high_n) && legacy_select && !system_bus_mode_strap
                 && !async_done_request && !arbiter_address_enable_n) begin
      wait_r <= answer_delay;
    end
  end
endmodule : wbca_bus_partner
`default_nettype wire

/* File: testbench.sv */
// testbench: self-checking bench for the word bus cycle adapter
`timescale 1ns/1ns
`default_nettype none
module testbench
  import wbca_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic cycle_start = 1'b0;
  logic legacy_cycle = 1'b0;
  logic data_code = 1'b0;
  logic mem_io = 1'b0;
  logic write_read = 1'b0;
  logic [3:0] byte_lane_enables_n = 4'hf;
  logic [1:0] wait_count = 2'h2;
  logic [3:0] answer_delay = 4'h1;
  logic async_done_request, word_select, upper_byte_strobe_n, lower_byte_strobe_n;
  logic cycle_status_low_n, cycle_status_high_n, first_wait_tick, second_wait_tick;
  logic half_rate_clk, legacy_select, system_bus_mode_strap, done_ack_n;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  wbca_adapter u_dut (.clk, .reset_n, .clk_en, .cycle_start, .legacy_cycle, .data_code, .mem_io,
    .write_read, .byte_lane_enables_n, .wait_count, .async_done_request, .word_select,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .cycle_status_low_n, .cycle_status_high_n,
    .first_wait_tick, .second_wait_tick, .half_rate_clk, .legacy_select, .system_bus_mode_strap,
    .done_ack_n);
  wbca_bus_partner u_far (.clk, .reset_n, .cycle_status_low_n, .cycle_status_high_n, .legacy_select,
    .system_bus_mode_strap, .done_ack_n, .answer_delay, .async_done_request);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  // expected {word_select, upper strobe, lower strobe} for each legal lane pattern
  function automatic logic [2:0] lane_exp(input logic [3:0] e);
    case (e)
      4'h1: lane_exp = 3'h2;
      4'h2: lane_exp = 3'h1;
      4'h4: lane_exp = 3'h6;
      4'h6: lane_exp = 3'h1;
      4'h8: lane_exp = 3'h5;
      4'hc: lane_exp = 3'h4;
      4'he: lane_exp = 3'h1;
      default: lane_exp = 3'h0;
    endcase
  endfunction : lane_exp
  task automatic test_lanes();
    logic [15:0] legal;
    logic [3:0] e;
    logic [2:0] got;
    legal = 16'hd1de;
    for (int p = 0; p < 16; p++) begin
      e = 4'(p);
      byte_lane_enables_n = ~e;
      tick(2);
      got = {word_select, upper_byte_strobe_n, lower_byte_strobe_n};
      if (legal[p]) chk({5'h0, got}, {5'h0, lane_exp(e)}, "lanes");
    end
    $display("test lanes done");
  endtask : test_lanes
  task automatic test_half_clock();
    logic h;
    h = half_rate_clk;
    tick(1);
    chk({7'h0, half_rate_clk}, {7'h0, ~h}, "half toggle");
    clk_en = 1'b0;
    h = half_rate_clk;
    tick(3);
    chk({7'h0, half_rate_clk}, {7'h0, h}, "half frozen");
    clk_en = 1'b1;
    $display("test half clock done");
  endtask : test_half_clock
  // start held over two edges: the second lands in a wait and must be ignored
  task automatic run_cycle(input logic [2:0] kind, input logic [1:0] waits);
    int n;
    {data_code, mem_io, write_read} = kind;
    wait_count = waits;
    legacy_cycle = 1'b1;
    cycle_start = 1'b1;
    tick(1);
    chk({legacy_select, first_wait_tick, system_bus_mode_strap, 5'h0}, 8'h80,
      "pre");
    for (n = 0; n < int'(STATUS_HOLD_CLKS); n++) begin
      tick(1);
      cycle_start = 1'b0;
      chk({done_ack_n, first_wait_tick, second_wait_tick, cycle_status_high_n, 4'h0},
        {1'b1, n == 0, n == 1, write_read & mem_io, 4'h0}, "wait");
      chk({7'h0, cycle_status_low_n}, {7'h0, ~(mem_io & (write_read | ~data_code))}, "low");
    end
    tick(1);
    chk({first_wait_tick, second_wait_tick, cycle_status_high_n, cycle_status_low_n, 4'h0}, 8'h30,
      "end");
    for (n = 0; n < 40 && done_ack_n !== 1'b0; n++) tick(1);
    for (n = 0; n < 8 && done_ack_n === 1'b0; n++) tick(1);
    chk(8'(n), 8'(DONE_HOLD_CLKS), "done width");
    legacy_cycle = 1'b0;
    tick(3);
    $display("test cycle %0h done", kind);
  endtask : run_cycle
  // reset dropped in the middle of a cycle must leave nothing behind
  task automatic test_mid_reset();
    {data_code, mem_io, write_read} = 3'h3;
    legacy_cycle = 1'b1;
    cycle_start = 1'b1;
    tick(2);
    cycle_start = 1'b0;
    chk({first_wait_tick, cycle_status_low_n, 6'h0}, 8'h80, "mid cycle");
    reset_n = 1'b0;
    tick(1);
    chk({done_ack_n, half_rate_clk, system_bus_mode_strap, upper_byte_strobe_n, lower_byte_strobe_n,
      cycle_status_low_n, cycle_status_high_n, first_wait_tick}, 8'h9e, "mid reset");
    chk({second_wait_tick, legacy_select, word_select, 5'h0}, 8'h0, "mid reset rest");
    reset_n = 1'b1;
    legacy_cycle = 1'b0;
    tick(2);
    chk({first_wait_tick, second_wait_tick, cycle_status_high_n, cycle_status_low_n, done_ack_n, 3'h0}, 8'h38,
      "after reset");
    $display("test mid reset done");
  endtask : test_mid_reset
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      give_verdict();
    end
  end
  initial begin
    tick(16);
    chk({done_ack_n, half_rate_clk, system_bus_mode_strap, upper_byte_strobe_n, lower_byte_strobe_n,
      cycle_status_low_n, cycle_status_high_n, first_wait_tick}, 8'h9e, "reset");
    reset_n = 1'b1;
    test_lanes();
    test_half_clock();
    for (int k = 0; k < 8; k++) run_cycle(3'(k), 2'(k));
    test_mid_reset();
    answer_delay = 4'h5;
    run_cycle(3'h3, 2'h3);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
